// ==== rtl/timer8_compare_pwm_regs.v ====
`include "timer8_regs.vh"

module timer8_compare_pwm_regs #(
	parameter PRESCALE_WIDTH = 10
) (
	input wire clk_sys,
	input wire reset_n,
	input wire [2:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire global_irq_en,
	input wire compare_vec_ack,
	input wire overflow_vec_ack,
	input wire ext_count_pin,
	input wire port_data_out,
	input wire port_dir_out,
	output reg wave_out_pin_o,
	output reg wave_out_pin_oe,
	output reg compare_irq_req,
	output reg overflow_irq_req
);

////////////////////////////////////////////////////////////////////////////////
// Register state
reg [7:0] control_q;
reg [7:0] count_q;
reg [7:0] compare_buf_q;
reg [7:0] compare_act_q;
reg [1:0] irq_mask_q;
reg compare_flag_q;
reg overflow_flag_q;
reg dir_down_q;
reg block_q;
reg wave_q;
reg [PRESCALE_WIDTH-1:0] prescale_q;
reg ext_s1_q;
reg ext_s2_q;
reg ext_s3_q;
reg ext_level_q;

wire [1:0] wave_mode_sel = {control_q[`TMR_BIT_WAVE_HI], control_q[`TMR_BIT_WAVE_LO]};
wire [1:0] compare_out_mode = control_q[`TMR_BIT_COM_HI:`TMR_BIT_COM_LO];
wire [2:0] clock_source_sel = control_q[`TMR_BIT_CS_HI:`TMR_BIT_CS_LO];

wire wr_control = reg_wr && (reg_addr == `TMR_OFS_CONTROL_A);
wire wr_count = reg_wr && (reg_addr == `TMR_OFS_COUNT);
wire wr_compare = reg_wr && (reg_addr == `TMR_OFS_COMPARE);
wire wr_mask = reg_wr && (reg_addr == `TMR_OFS_IRQ_MASK);
wire wr_flags = reg_wr && (reg_addr == `TMR_OFS_IRQ_FLAGS);

// PWM modes have the low mode bit set
function is_pwm;
	input [1:0] mode;
	begin
		is_pwm = (mode == `TMR_WAVE_PC_PWM) || (mode == `TMR_WAVE_FAST_PWM);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Prescaler and clock select
// Free running; a tap ticks when all its low bits are ones, so the first
// count after enabling may come anywhere from 1 to N system cycles later.
always @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		prescale_q <= {PRESCALE_WIDTH{1'b0}};
	end else begin
		prescale_q <= prescale_q + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
	end
end

// External pin: three flops; a new level counts once the second and third agree,
// so a one-cycle glitch on the pin never clocks the counter
always @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		ext_s1_q <= 1'b0;
		ext_s2_q <= 1'b0;
		ext_s3_q <= 1'b0;
		ext_level_q <= 1'b0;
	end else begin
		ext_s1_q <= ext_count_pin;
		ext_s2_q <= ext_s1_q;
		ext_s3_q <= ext_s2_q;
		if (ext_s2_q == ext_s3_q) begin
			ext_level_q <= ext_s3_q;
		end
	end
end

wire ext_agree = (ext_s2_q == ext_s3_q);
wire ext_rise = ext_agree && ext_s3_q && !ext_level_q;
wire ext_fall = ext_agree && !ext_s3_q && ext_level_q;

reg tick;
always @* begin
	case (clock_source_sel)
	`TMR_CS_STOP: tick = 1'b0;
	`TMR_CS_DIV1: tick = 1'b1;
	`TMR_CS_DIV8: tick = &prescale_q[2:0];
	`TMR_CS_DIV64: tick = &prescale_q[5:0];
	`TMR_CS_DIV256: tick = &prescale_q[7:0];
	`TMR_CS_DIV1024: tick = &prescale_q[9:0];
	`TMR_CS_EXT_FALL: tick = ext_fall;
	`TMR_CS_EXT_RISE: tick = ext_rise;
	default: tick = 1'b0;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Count sequence
wire at_max = (count_q == `TMR_MAX);
wire at_bottom = (count_q == `TMR_BOTTOM);
wire raw_match = (count_q == compare_act_q);
wire match = tick && raw_match && !block_q;
wire pwm_mode = is_pwm(wave_mode_sel);
wire top_ignore = pwm_mode && compare_out_mode[1] && (compare_act_q == `TMR_MAX);
// At bottom the phase-correct counter is turning upward
wire pc_down = dir_down_q && !at_bottom;

reg [7:0] count_d;
reg dir_down_d;
reg overflow_evt;
reg at_top_tick;
always @* begin
	count_d = count_q;
	dir_down_d = dir_down_q;
	overflow_evt = 1'b0;
	at_top_tick = 1'b0;
	if (tick) begin
		case (wave_mode_sel)
		`TMR_WAVE_NORMAL: begin
			count_d = count_q + 8'h01;
			overflow_evt = at_max;
		end
		`TMR_WAVE_CTC: begin
			// Clearing uses the raw compare, so a forced strobe cannot clear
			count_d = raw_match ? `TMR_BOTTOM : count_q + 8'h01;
			overflow_evt = at_max;
		end
		`TMR_WAVE_FAST_PWM: begin
			count_d = count_q + 8'h01;
			overflow_evt = at_max;
			at_top_tick = at_max;
		end
		`TMR_WAVE_PC_PWM: begin
			if (!dir_down_q) begin
				if (at_max) begin
					dir_down_d = 1'b1;
					count_d = count_q - 8'h01;
					at_top_tick = 1'b1;
				end else begin
					count_d = count_q + 8'h01;
				end
			end else begin
				if (at_bottom) begin
					dir_down_d = 1'b0;
					count_d = count_q + 8'h01;
					overflow_evt = 1'b1;
				end else begin
					count_d = count_q - 8'h01;
				end
			end
		end
		default: count_d = count_q;
		endcase
	end
end

always @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		count_q <= `TMR_RST_COUNT;
		dir_down_q <= 1'b0;
		block_q <= 1'b0;
	end else begin
		if (wr_count) begin
			count_q <= reg_wdata;
			block_q <= 1'b1;
		end else begin
			count_q <= count_d;
			if (tick) begin
				block_q <= 1'b0;
			end
		end
		dir_down_q <= pwm_mode && (wave_mode_sel == `TMR_WAVE_PC_PWM) ? dir_down_d : 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Compare register, double buffered in PWM modes
always @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		compare_buf_q <= `TMR_RST_COMPARE;
		compare_act_q <= `TMR_RST_COMPARE;
	end else begin
		if (wr_compare) begin
			compare_buf_q <= reg_wdata;
		end
		// Updating only at TOP keeps PWM pulses glitch free
		if (!pwm_mode) begin
			compare_act_q <= wr_compare ? reg_wdata : compare_buf_q;
		end else if (at_top_tick) begin
			compare_act_q <= compare_buf_q;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Waveform unit
wire force_hit = wr_control && reg_wdata[`TMR_BIT_FORCE] && !pwm_mode;
reg wave_d;
always @* begin
	wave_d = wave_q;
	if (!pwm_mode) begin
		// The forced match uses the output mode already stored
		if (match || force_hit) begin
			case (compare_out_mode)
			2'h1: wave_d = !wave_q;
			2'h2: wave_d = 1'b0;
			2'h3: wave_d = 1'b1;
			default: wave_d = wave_q;
			endcase
		end
	end else if (wave_mode_sel == `TMR_WAVE_FAST_PWM) begin
		if (compare_out_mode[1]) begin
			if (at_top_tick) begin
				wave_d = !compare_out_mode[0];
			end else if (match && !top_ignore) begin
				wave_d = compare_out_mode[0];
			end
		end else if (compare_out_mode == 2'h1 && match) begin
			wave_d = !wave_q;
		end
	end else begin
		if (compare_out_mode[1]) begin
			if (top_ignore) begin
				if (at_top_tick) begin
					wave_d = !compare_out_mode[0];
				end
			end else if (match) begin
				wave_d = pc_down ? !compare_out_mode[0] : compare_out_mode[0];
			end
		end
	end
end

always @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		wave_q <= 1'b0;
		wave_out_pin_o <= 1'b0;
		wave_out_pin_oe <= 1'b0;
	end else begin
		wave_q <= wave_d;
		// Direction bit still gates the driver when the wave owns the pin
		wave_out_pin_o <= (compare_out_mode != 2'h0) ? wave_q : port_data_out;
		wave_out_pin_oe <= port_dir_out;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control, mask and flags
always @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		control_q <= `TMR_RST_CONTROL_A;
		irq_mask_q <= 2'h0;
		compare_flag_q <= 1'b0;
		overflow_flag_q <= 1'b0;
	end else begin
		if (wr_control) begin
			// Strobe bit is never stored
			control_q <= {1'b0, reg_wdata[6:0]};
		end
		if (wr_mask) begin
			irq_mask_q <= {reg_wdata[`TMR_BIT_COMPARE], reg_wdata[`TMR_BIT_OVERFLOW]};
		end
		// Hardware set wins over a clear in the same cycle; force_hit never sets
		if (match) begin
			compare_flag_q <= 1'b1;
		end else if (compare_vec_ack || (wr_flags && reg_wdata[`TMR_BIT_COMPARE])) begin
			compare_flag_q <= 1'b0;
		end
		if (overflow_evt) begin
			overflow_flag_q <= 1'b1;
		end else if (overflow_vec_ack || (wr_flags && reg_wdata[`TMR_BIT_OVERFLOW])) begin
			overflow_flag_q <= 1'b0;
		end
	end
end

always @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		compare_irq_req <= 1'b0;
		overflow_irq_req <= 1'b0;
	end else begin
		compare_irq_req <= irq_mask_q[1] && global_irq_en && compare_flag_q;
		overflow_irq_req <= irq_mask_q[0] && global_irq_en && overflow_flag_q;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read port
reg [7:0] rdata_d;
always @* begin
	case (reg_addr)
	`TMR_OFS_CONTROL_A: rdata_d = {1'b0, control_q[6:0]};
	`TMR_OFS_COUNT: rdata_d = count_q;
	`TMR_OFS_COMPARE: rdata_d = compare_buf_q;
	`TMR_OFS_IRQ_MASK: rdata_d = {6'h00, irq_mask_q};
	`TMR_OFS_IRQ_FLAGS: rdata_d = {6'h00, compare_flag_q, overflow_flag_q};
	default: rdata_d = 8'h00;
	endcase
end

always @(posedge clk_sys or negedge reset_n) begin
	if (!reset_n) begin
		reg_rdata <= 8'h00;
	end else begin
		reg_rdata <= reg_rd ? rdata_d : 8'h00;
	end
end

endmodule

// ==== shared/timer8_regs.vh ====
`ifndef TIMER8_REGS_VH
`define TIMER8_REGS_VH

// Register offsets on the plain register port
`define TMR_OFS_CONTROL_A 3'h0
`define TMR_OFS_COUNT 3'h1
`define TMR_OFS_COMPARE 3'h2
`define TMR_OFS_IRQ_MASK 3'h3
`define TMR_OFS_IRQ_FLAGS 3'h4

// timer_control_a fields
`define TMR_BIT_FORCE 7
`define TMR_BIT_WAVE_LO 6
`define TMR_BIT_COM_HI 5
`define TMR_BIT_COM_LO 4
`define TMR_BIT_WAVE_HI 3
`define TMR_BIT_CS_HI 2
`define TMR_BIT_CS_LO 0

// Mask and flag bit positions
`define TMR_BIT_COMPARE 1
`define TMR_BIT_OVERFLOW 0

// Reset values
`define TMR_RST_CONTROL_A 8'h00
`define TMR_RST_COUNT 8'h00
`define TMR_RST_COMPARE 8'h00
`define TMR_RST_IRQ_MASK 8'h00
`define TMR_RST_IRQ_FLAGS 8'h00

// Wave modes
`define TMR_WAVE_NORMAL 2'h0
`define TMR_WAVE_PC_PWM 2'h1
`define TMR_WAVE_CTC 2'h2
`define TMR_WAVE_FAST_PWM 2'h3

// Clock select codes
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_CS_EXT_FALL 3'h6
`define TMR_CS_EXT_RISE 3'h7

// Counter limits
`define TMR_BOTTOM 8'h00
`define TMR_MAX 8'hFF

`endif

// ==== tb/timer8_monitor.sv ====
module timer8_monitor (
	input wire clk_sys,
	input wire reset_n,
	input wire [2:0] reg_addr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire global_irq_en,
	input wire port_dir_out,
	input wire wave_out_pin_o,
	input wire wave_out_pin_oe,
	input wire compare_irq_req,
	input wire overflow_irq_req
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	a_force_reads_zero: assert property (reg_rd && reg_addr == 3'h0 |=> !reg_rdata[7])
		else $error("force bit read as one");
	a_unmapped_zero: assert property (reg_rd && reg_addr > 3'h4 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_mask_high_zero: assert property (reg_rd && reg_addr == 3'h3 |=> reg_rdata[7:2] == 6'h00)
		else $error("mask upper bits set");
	a_flag_high_zero: assert property (reg_rd && reg_addr == 3'h4 |=> reg_rdata[7:2] == 6'h00)
		else $error("flag upper bits set");
	a_dir_to_oe: assert property ($past(reset_n) |-> wave_out_pin_oe == $past(port_dir_out))
		else $error("drive enable not following direction");
	a_cmp_gated: assert property (compare_irq_req |-> $past(global_irq_en))
		else $error("compare request without global enable");
	a_ovf_gated: assert property (overflow_irq_req |-> $past(global_irq_en))
		else $error("overflow request without global enable");
	cover property (compare_irq_req);
	cover property (overflow_irq_req);
	cover property ($rose(wave_out_pin_o));
endmodule

// ==== tb/port_pin_model.sv ====
module port_pin_model (
	input wire clk_sys,
	input wire pulse_req,
	input wire pin_o,
	input wire pin_oe,
	output wire ext_count_pin,
	output wire pin_level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] left_q = 4'h0;
	// Pull-up holds the pad high whenever nobody drives it
	assign pin_level = pin_oe ? pin_o : 1'b1;
	// Four clocks per half period so the sampler cannot miss an edge
	assign ext_count_pin = left_q > 4'h4;
	always @(posedge clk_sys) begin
		if (pulse_req)
			left_q <= 4'h8;
		else if (left_q != 4'h0)
			left_q <= left_q - 4'h1;
	end
endmodule

// ==== tb/tb_top.sv ====
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic global_irq_en = 1'b0;
	logic compare_vec_ack = 1'b0;
	logic overflow_vec_ack = 1'b0;
	logic port_data_out = 1'b0;
	logic port_dir_out = 1'b0;
	logic pulse_req = 1'b0;
	logic [7:0] v;
	wire [7:0] reg_rdata;
	wire ext_count_pin, wave_out_pin_o, wave_out_pin_oe, compare_irq_req, overflow_irq_req;
	wire pin_level;
	int failures = 0;
	int n_checks = 0;
	timer8_compare_pwm_regs i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.global_irq_en(global_irq_en), .compare_vec_ack(compare_vec_ack),
		.overflow_vec_ack(overflow_vec_ack), .ext_count_pin(ext_count_pin),
		.port_data_out(port_data_out), .port_dir_out(port_dir_out),
		.wave_out_pin_o(wave_out_pin_o), .wave_out_pin_oe(wave_out_pin_oe),
		.compare_irq_req(compare_irq_req), .overflow_irq_req(overflow_irq_req));
	port_pin_model i_pin (.clk_sys(clk_sys), .pulse_req(pulse_req), .pin_o(wave_out_pin_o),
		.pin_oe(wave_out_pin_oe), .ext_count_pin(ext_count_pin), .pin_level(pin_level));
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Write strobe stays up so two writes can go back to back; rd or idle drops it
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic highs(input int n, output int hi);
		hi = 0;
		repeat (n) begin
			@(negedge clk_sys);
			hi += (pin_level === 1'b1);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			reg_wr <= 1'b0;
			compare_vec_ack <= 1'b0;
			overflow_vec_ack <= 1'b0;
			pulse_req <= 1'b0;
		end
	endtask
	function automatic logic [7:0] ctl(input logic [1:0] m, input logic [1:0] c, input logic [2:0] s);
		return {1'b0, m[0], c, m[1], s};
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	task automatic s_regs;
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), v);
			check("reset value", v, 8'h00);
		end
		wr(3'h0, 8'hB8);
		rd(3'h0, v);
		check("control", v, 8'h38);
		wr(3'h3, 8'hFF);
		wr(3'h5, 8'hFF);
		rd(3'h3, v);
		check("mask", v, 8'h03);
		rd(3'h5, v);
		check("unmapped", v, 8'h00);
		wr(3'h2, 8'hA5);
		wr(3'h1, 8'h5A);
		wr(3'h3, 8'h00);
		rd(3'h2, v);
		check("compare", v, 8'hA5);
		rd(3'h1, v);
		check("count", v, 8'h5A);
	endtask
	task automatic s_force;
		logic [1:0] coms [4] = '{2'h2, 2'h3, 2'h1, 2'h1};
		logic [3:0] exp = 4'b1010;
		for (int i = 0; i < 4; i++) begin
			wr(3'h0, ctl(i > 1 ? 2'h2 : 2'h0, coms[i], 3'h0));
			wr(3'h0, ctl(i > 1 ? 2'h2 : 2'h0, coms[i], 3'h0) | 8'h80);
			idle(3);
			check("wave pin", {7'h00, pin_level}, {7'h00, exp[i]});
		end
		rd(3'h1, v);
		check("count after force", v, 8'h5A);
		rd(3'h4, v);
		check("flags after force", v, 8'h00);
		@(posedge clk_sys);
		port_data_out <= 1'b1;
		wr(3'h0, 8'h00);
		idle(3);
		check("port value", {7'h00, pin_level}, 8'h01);
	endtask
	// One timer tick from MAX: write count, start the clock, stop it on the next edge
	task automatic s_ticks;
		wr(3'h2, 8'hFF);
		for (int m = 0; m < 4; m++) begin
			wr(3'h4, 8'h03);
			wr(3'h1, 8'hFF);
			wr(3'h0, ctl(2'(m), 2'h0, 3'h1));
			wr(3'h0, ctl(2'(m), 2'h0, 3'h0));
			rd(3'h1, v);
			check("count after max", v, m == 1 ? 8'hFE : 8'h00);
			rd(3'h4, v);
			check("flags after max", v, m == 1 ? 8'h00 : 8'h01);
		end
	endtask
	task automatic s_prescale;
		int divs [5] = '{1, 8, 64, 256, 1024};
		logic [7:0] last;
		for (int i = 0; i < 5; i++) begin
			wr(3'h1, 8'h00);
			wr(3'h0, ctl(2'h0, 2'h0, 3'(i + 1)));
			idle(10 * divs[i]);
			wr(3'h0, 8'h00);
			rd(3'h1, v);
			check("prescaled count", {7'h00, v >= 8'h09 && v <= 8'h0B}, 8'h01);
		end
		last = v;
		idle(20);
		rd(3'h1, v);
		check("stopped count", v, last);
	endtask
	task automatic s_ext;
		wr(3'h1, 8'h00);
		for (int k = 0; k < 5; k++) begin
			if (k == 0 || k == 3)
				wr(3'h0, ctl(2'h0, 2'h0, k == 0 ? 3'h7 : 3'h6));
			@(posedge clk_sys);
			reg_wr <= 1'b0;
			pulse_req <= 1'b1;
			idle(12);
		end
		wr(3'h0, 8'h00);
		rd(3'h1, v);
		check("external count", v, 8'h05);
	endtask
	task automatic s_irq;
		wr(3'h3, 8'h03);
		wr(3'h2, 8'h03);
		wr(3'h1, 8'h00);
		wr(3'h4, 8'h03);
		wr(3'h0, ctl(2'h0, 2'h0, 3'h1));
		idle(4);
		wr(3'h0, 8'h00);
		rd(3'h4, v);
		check("compare flag", v, 8'h02);
		check("masked request", {7'h00, compare_irq_req}, 8'h00);
		@(posedge clk_sys);
		global_irq_en <= 1'b1;
		idle(2);
		check("compare request", {7'h00, compare_irq_req}, 8'h01);
		compare_vec_ack <= 1'b1;
		idle(3);
		check("compare acked", {7'h00, compare_irq_req}, 8'h00);
		wr(3'h1, 8'hFE);
		wr(3'h0, ctl(2'h0, 2'h0, 3'h1));
		idle(2);
		wr(3'h0, 8'h00);
		idle(2);
		check("overflow request", {7'h00, overflow_irq_req}, 8'h01);
		wr(3'h4, 8'h01);
		idle(3);
		check("overflow cleared", {7'h00, overflow_irq_req}, 8'h00);
		rd(3'h4, v);
		check("flags cleared", v, 8'h00);
	endtask
	// Duty counts are taken over whole periods, so the phase of the window does not matter
	task automatic s_wave;
		int hi;
		wr(3'h1, 8'h00);
		wr(3'h2, 8'h04);
		wr(3'h0, ctl(2'h2, 2'h1, 3'h1));
		idle(20);
		highs(100, hi);
		check("ctc toggle", 8'(hi), 8'h32);
		wr(3'h2, 8'h40);
		wr(3'h0, ctl(2'h3, 2'h2, 3'h1));
		idle(300);
		highs(256, hi);
		check("fast pwm high", 8'(hi), 8'h41);
		wr(3'h0, ctl(2'h1, 2'h2, 3'h1));
		idle(600);
		highs(510, hi);
		check("pc pwm high", 8'(hi), 8'h80);
		wr(3'h2, 8'hFF);
		idle(1100);
		highs(510, hi);
		check("pc pwm at top", 8'(510 - hi), 8'h00);
		wr(3'h0, 8'h00);
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		overflow_vec_ack <= 1'b1;
		idle(2);
		rd(3'h4, v);
		check("overflow acked", v, 8'h02);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clk_sys);
		failures++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		port_dir_out <= 1'b1;
		s_regs();
		s_force();
		s_ticks();
		s_prescale();
		s_ext();
		s_irq();
		s_wave();
		finish_test();
	end
endmodule

bind timer8_compare_pwm_regs timer8_monitor i_mon (.clk_sys(clk_sys), .reset_n(reset_n),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_irq_en(global_irq_en),
	.port_dir_out(port_dir_out), .wave_out_pin_o(wave_out_pin_o),
	.wave_out_pin_oe(wave_out_pin_oe), .compare_irq_req(compare_irq_req),
	.overflow_irq_req(overflow_irq_req));
